// ===== lsdr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module lsdr_host_model (
    // Clock
    input wire logic clk,
    // Serial pins
    output logic spiCsN,
    output logic spiSclk,
    output logic spiMosi,
    input wire logic spiMiso
);
    initial begin
        spiCsN = 1'b1;
        spiSclk = 1'b0;
        spiMosi = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Each serial clock level lasts four system clocks so the slave always sees it.
    task automatic xfer(input logic [15:0] frame, output logic [7:0] rdData);
        rdData = 8'h00;
        @(negedge clk);
        spiCsN = 1'b0;
        repeat (2) @(negedge clk);
        for (int i = 15; i >= 0; i--) begin
            spiMosi = frame[i];
            repeat (4) @(negedge clk);
            if (i < 8) rdData[i] = spiMiso;
            spiSclk = 1'b1;
            repeat (4) @(negedge clk);
            spiSclk = 1'b0;
        end
        repeat (4) @(negedge clk);
        spiCsN = 1'b1;
        // A released data line must not look like a held bit.
        spiMosi = ~spiMosi;
        repeat (3) @(negedge clk);
    endtask : xfer
endmodule : lsdr_host_model
`default_nettype wire

// ===== lsdr_pkg.sv
`default_nettype none
package lsdr_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial frame layout.
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int CMD_READ_BIT = 7;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;

    ////////////////////////////////////////////////////////////////////////////////
    // Register addresses.
    localparam logic [ADDR_W-1:0] ADDR_LINE_FEED_CONTROL = 7'h06;
    localparam logic [ADDR_W-1:0] ADDR_LINE_DETECT_STATUS = 7'h09;
    localparam logic [ADDR_W-1:0] ADDR_CODEC_LOOPBACK_CONTROL = 7'h16;

    ////////////////////////////////////////////////////////////////////////////////
    // Field positions.
    localparam int CMD_STATE_LSB = 0;
    localparam int CMD_STATE_MSB = 2;
    localparam int ACT_STATE_LSB = 4;
    localparam int ACT_STATE_MSB = 6;
    localparam int LOOPBACK_EN_BIT = 7;
    localparam int DET_LOOP_CLOSURE_BIT = 0;
    localparam int DET_RING_TRIP_BIT = 1;
    localparam int DET_GROUND_KEY_BIT = 2;
    localparam int DET_VOC_TRACK_BIT = 3;
    localparam int DET_SPEEDUP_BIT = 4;
    localparam int DET_COMMON_MODE_BIT = 5;
    localparam int DET_FLAG_COUNT = 6;

    ////////////////////////////////////////////////////////////////////////////////
    // Line feed state codes.
    localparam logic [2:0] LS_OPEN = 3'h0;
    localparam logic [2:0] LS_FWD_ACTIVE = 3'h1;
    localparam logic [2:0] LS_FWD_ON_HOOK = 3'h2;
    localparam logic [2:0] LS_TIP_OPEN = 3'h3;
    localparam logic [2:0] LS_RINGING = 3'h4;
    localparam logic [2:0] LS_REV_ACTIVE = 3'h5;
    localparam logic [2:0] LS_REV_ON_HOOK = 3'h6;
    localparam logic [2:0] LS_RING_OPEN = 3'h7;

    ////////////////////////////////////////////////////////////////////////////////
    // Reset values.
    localparam logic [2:0] LINE_STATE_RESET = LS_OPEN;
    localparam logic [7:0] LOOPBACK_RESET = 8'h00;
    localparam logic [7:0] READ_ZERO = 8'h00;

endpackage : lsdr_pkg
`default_nettype wire

// ===== lsdr_regs.sv
// What this block does
// - Bit 7 of the codec loopback register turns codec loopback on when 1, and the register resets to 0x00.
// - Detect status bit 5 reads 1 while the common-mode level is over its threshold.
// - Detect status bit 4 reads 1 while automatic speed-up is in effect and 0 when it is off.
// - Detect status bit 3 reads 1 while open-circuit voltage tracking applies after a battery drop.
// - Detect status bit 2 reads 1 while a ground key is detected.
// - Detect status bit 1 reads 1 while a ring trip is detected.
// - Detect status bit 0 reads 1 while a loop closure is detected.
// - The detect flags follow the live condition and never latch.
// - Bits 6:4 of the line feed register read the actual line state with the same codes.
// - The actual state field follows what the line really does, not the written command.
// - While ringing is commanded the actual field shows ringing in bursts and forward on-hook between.
`timescale 1ns/1ps
`default_nettype none
module lsdr_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial control port
    input wire logic spiCsN,
    input wire logic spiSclk,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    // Live line conditions
    input wire logic loopClosureDet,
    input wire logic ringTripDet,
    input wire logic groundKeyDet,
    input wire logic openVoltageTrackDet,
    input wire logic speedupActive,
    input wire logic commonModeOverDet,
    // Automatic line control
    input wire logic ringBurstActive,
    input wire logic autoStateValid,
    input wire logic [2:0] autoState,
    // Control outputs
    output logic [2:0] commandedLineState,
    output logic [2:0] actualLineState,
    output logic codecLoopbackEn
);

    logic [lsdr_pkg::ADDR_W-1:0] regAddr;
    logic regWrEn;
    logic [lsdr_pkg::DATA_W-1:0] regWrData;
    logic [lsdr_pkg::DATA_W-1:0] regRdData;
    logic [lsdr_pkg::DET_FLAG_COUNT-1:0] detRaw;
    logic [lsdr_pkg::DET_FLAG_COUNT-1:0] detFlags_r;
    logic [2:0] actualLineState_nxt;

    ////////////////////////////////////////////////////////////////////////////////
    lsdr_spi_slave uSpi (
        .clk(clk),
        .rst(rst),
        .spiCsN(spiCsN),
        .spiSclk(spiSclk),
        .spiMosi(spiMosi),
        .spiMiso(spiMiso),
        .spiMisoOe(spiMisoOe),
        .regAddr(regAddr),
        .regWrEn(regWrEn),
        .regWrData(regWrData),
        .regRdData(regRdData)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Commanded line state; only the command field of a write is used.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            commandedLineState <= lsdr_pkg::LINE_STATE_RESET;
        end else if (regWrEn && regAddr == lsdr_pkg::ADDR_LINE_FEED_CONTROL) begin
            commandedLineState <= regWrData[lsdr_pkg::CMD_STATE_MSB:lsdr_pkg::CMD_STATE_LSB];
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            codecLoopbackEn <= lsdr_pkg::LOOPBACK_RESET[lsdr_pkg::LOOPBACK_EN_BIT];
        end else if (regWrEn && regAddr == lsdr_pkg::ADDR_CODEC_LOOPBACK_CONTROL) begin
            codecLoopbackEn <= regWrData[lsdr_pkg::LOOPBACK_EN_BIT];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // An automatic override, such as a fault response, takes precedence over cadence.
    always_comb begin
        if (autoStateValid) begin
            actualLineState_nxt = autoState;
        end else if (commandedLineState == lsdr_pkg::LS_RINGING) begin
            actualLineState_nxt = ringBurstActive ? lsdr_pkg::LS_RINGING
                                                  : lsdr_pkg::LS_FWD_ON_HOOK;
        end else begin
            actualLineState_nxt = commandedLineState;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            actualLineState <= lsdr_pkg::LINE_STATE_RESET;
        end else begin
            actualLineState <= actualLineState_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flags are resampled every cycle so that they never hold past the condition.
    assign detRaw[lsdr_pkg::DET_LOOP_CLOSURE_BIT] = loopClosureDet;
    assign detRaw[lsdr_pkg::DET_RING_TRIP_BIT] = ringTripDet;
    assign detRaw[lsdr_pkg::DET_GROUND_KEY_BIT] = groundKeyDet;
    assign detRaw[lsdr_pkg::DET_VOC_TRACK_BIT] = openVoltageTrackDet;
    assign detRaw[lsdr_pkg::DET_SPEEDUP_BIT] = speedupActive;
    assign detRaw[lsdr_pkg::DET_COMMON_MODE_BIT] = commonModeOverDet;

    genvar gi;
    generate
        for (gi = 0; gi < lsdr_pkg::DET_FLAG_COUNT; gi++) begin : gDet
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    detFlags_r[gi] <= 1'b0;
                end else begin
                    detFlags_r[gi] <= detRaw[gi];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // Read multiplexer; unmapped addresses and reserved bits return zero.
    always_comb begin
        regRdData = lsdr_pkg::READ_ZERO;
        if (regAddr == lsdr_pkg::ADDR_LINE_FEED_CONTROL) begin
            regRdData[lsdr_pkg::CMD_STATE_MSB:lsdr_pkg::CMD_STATE_LSB] = commandedLineState;
            regRdData[lsdr_pkg::ACT_STATE_MSB:lsdr_pkg::ACT_STATE_LSB] = actualLineState;
        end else if (regAddr == lsdr_pkg::ADDR_LINE_DETECT_STATUS) begin
            regRdData[lsdr_pkg::DET_FLAG_COUNT-1:0] = detFlags_r;
        end else if (regAddr == lsdr_pkg::ADDR_CODEC_LOOPBACK_CONTROL) begin
            regRdData[lsdr_pkg::LOOPBACK_EN_BIT] = codecLoopbackEn;
        end
    end

endmodule : lsdr_regs
`default_nettype wire

// ===== lsdr_regs_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module lsdr_regs_monitor (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial control port
    input wire logic spiCsN,
    input wire logic spiSclk,
    input wire logic spiMosi,
    input wire logic spiMiso,
    input wire logic spiMisoOe,
    // Live line conditions
    input wire logic loopClosureDet,
    input wire logic ringTripDet,
    input wire logic groundKeyDet,
    input wire logic openVoltageTrackDet,
    input wire logic speedupActive,
    input wire logic commonModeOverDet,
    // Automatic line control
    input wire logic ringBurstActive,
    input wire logic autoStateValid,
    input wire logic [2:0] autoState,
    // Control outputs
    input wire logic [2:0] commandedLineState,
    input wire logic [2:0] actualLineState,
    input wire logic codecLoopbackEn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    ////////////////////////////////////////////////////////////////////////////////
    // A write lands a few cycles after its last bit, so the select may have just risen.
    sequence s_frame_recent;
        !spiCsN || !$past(spiCsN) || !$past(spiCsN, 2) || !$past(spiCsN, 3);
    endsequence
    sequence s_ring_cmd;
        commandedLineState == 3'h4 && $stable(commandedLineState) && !autoStateValid && !$past(rst);
    endsequence

    property p_reset_clear;
        $fell(rst) |-> codecLoopbackEn == 1'b0 && commandedLineState == 3'h0;
    endproperty
    property p_loopback_in_frame;
        $changed(codecLoopbackEn) |-> s_frame_recent;
    endproperty
    property p_cmd_in_frame;
        $changed(commandedLineState) |-> s_frame_recent;
    endproperty
    property p_burst;
        s_ring_cmd ##0 ringBurstActive |=> actualLineState == 3'h4;
    endproperty
    property p_silence;
        s_ring_cmd ##0 !ringBurstActive |=> actualLineState == 3'h2;
    endproperty
    property p_cadence;
        s_ring_cmd ##0 ringBurstActive ##1 s_ring_cmd ##0 !ringBurstActive
            |=> actualLineState == 3'h2 && $past(actualLineState) == 3'h4;
    endproperty
    property p_auto;
        autoStateValid && !$past(rst) |=> actualLineState == $past(autoState);
    endproperty
    property p_oe_select;
        !$past(rst) |-> spiMisoOe == !$past(spiCsN);
    endproperty
    property p_follow;
        !autoStateValid && commandedLineState != 3'h4 && $stable(commandedLineState) && !$past(rst)
            |=> actualLineState == $past(commandedLineState);
    endproperty

    a_reset_clear: assert property (p_reset_clear) else $error("outputs not cleared");
    a_loopback_in_frame: assert property (p_loopback_in_frame) else $error("stray loopback");
    a_cmd_in_frame: assert property (p_cmd_in_frame) else $error("stray command change");
    a_burst: assert property (p_burst) else $error("burst not shown");
    a_silence: assert property (p_silence) else $error("silence not shown");
    a_cadence: assert property (p_cadence) else $error("cadence not tracked");
    a_auto: assert property (p_auto) else $error("automatic state ignored");
    a_follow: assert property (p_follow) else $error("actual state off command");
    a_oe_select: assert property (p_oe_select) else $error("bad enable");
endmodule : lsdr_regs_monitor

bind lsdr_regs lsdr_regs_monitor i_lsdr_regs_monitor (.clk(clk), .rst(rst), .spiCsN(spiCsN),
    .spiSclk(spiSclk), .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(spiMisoOe),
    .loopClosureDet(loopClosureDet), .ringTripDet(ringTripDet), .groundKeyDet(groundKeyDet),
    .openVoltageTrackDet(openVoltageTrackDet), .speedupActive(speedupActive),
    .commonModeOverDet(commonModeOverDet), .ringBurstActive(ringBurstActive),
    .autoStateValid(autoStateValid), .autoState(autoState),
    .commandedLineState(commandedLineState), .actualLineState(actualLineState),
    .codecLoopbackEn(codecLoopbackEn));
`default_nettype wire

// ===== lsdr_spi_slave.sv
`timescale 1ns/1ps
`default_nettype none
module lsdr_spi_slave (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Serial pins, sampled on clk
    input wire logic spiCsN,
    input wire logic spiSclk,
    input wire logic spiMosi,
    output logic spiMiso,
    output logic spiMisoOe,
    // Register side
    output logic [lsdr_pkg::ADDR_W-1:0] regAddr,
    output logic regWrEn,
    output logic [lsdr_pkg::DATA_W-1:0] regWrData,
    input wire logic [lsdr_pkg::DATA_W-1:0] regRdData
);

    typedef enum logic [1:0] {sIdle, sCmd, sData, sDone} lsdr_spi_state_t;

    lsdr_spi_state_t state_r;
    logic sclkPrev_r;
    logic [3:0] bitCnt_r;
    logic [lsdr_pkg::DATA_W-1:0] inShift_r;
    logic [lsdr_pkg::DATA_W-1:0] outShift_r;
    logic isRead_r;
    logic loadPending_r;
    logic sclkRise;
    logic sclkFall;
    logic lastBit;
    logic [lsdr_pkg::DATA_W-1:0] inByte;

    assign sclkRise = spiSclk & ~sclkPrev_r;
    assign sclkFall = ~spiSclk & sclkPrev_r;
    assign lastBit = (bitCnt_r == lsdr_pkg::BITS_PER_BYTE - 4'h1);
    assign inByte = {inShift_r[lsdr_pkg::DATA_W-2:0], spiMosi};

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sclkPrev_r <= 1'b0;
        end else begin
            sclkPrev_r <= spiSclk;
        end
    end

    // Chip select high aborts any frame, so a partial frame never writes.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_r <= sIdle;
            bitCnt_r <= 4'h0;
            inShift_r <= 8'h00;
            isRead_r <= 1'b0;
            regAddr <= 7'h00;
            regWrEn <= 1'b0;
            regWrData <= 8'h00;
            loadPending_r <= 1'b0;
        end else begin
            regWrEn <= 1'b0;
            loadPending_r <= 1'b0;
            if (spiCsN) begin
                state_r <= sIdle;
                bitCnt_r <= 4'h0;
            end else begin
                unique case (state_r)
                    sIdle: begin
                        state_r <= sCmd;
                        bitCnt_r <= 4'h0;
                    end
                    sCmd, sData: begin
                        if (sclkRise) begin
                            inShift_r <= inByte;
                            bitCnt_r <= lastBit ? 4'h0 : bitCnt_r + 4'h1;
                            if (lastBit && state_r == sCmd) begin
                                isRead_r <= inByte[lsdr_pkg::CMD_READ_BIT];
                                regAddr <= inByte[lsdr_pkg::ADDR_W-1:0];
                                loadPending_r <= 1'b1;
                                state_r <= sData;
                            end else if (lastBit) begin
                                regWrEn <= ~isRead_r;
                                regWrData <= inByte;
                                state_r <= sDone;
                            end
                        end
                    end
                    sDone: begin
                        state_r <= sDone;
                    end
                endcase
            end
        end
    end

    // Read data is captured one cycle after the address is known.
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            outShift_r <= 8'h00;
            spiMiso <= 1'b0;
            spiMisoOe <= 1'b0;
        end else begin
            spiMisoOe <= ~spiCsN;
            if (spiCsN) begin
                spiMiso <= 1'b0;
            end else if (loadPending_r) begin
                outShift_r <= isRead_r ? regRdData : lsdr_pkg::READ_ZERO;
            end else if (sclkFall && state_r == sData) begin
                spiMiso <= outShift_r[lsdr_pkg::DATA_W-1];
                outShift_r <= {outShift_r[lsdr_pkg::DATA_W-2:0], 1'b0};
            end
        end
    end

endmodule : lsdr_spi_slave
`default_nettype wire

// ===== test_line_state_and_detect_regs.sv
`timescale 1ns/1ps
`default_nettype none
module test_line_state_and_detect_regs;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic spiCsN;
    logic spiSclk;
    logic spiMosi;
    logic spiMiso;
    logic [5:0] det = 6'h00;
    logic ringBurst = 1'b0;
    logic autoValid = 1'b0;
    logic [2:0] autoState = 3'h0;
    logic [2:0] cmdState;
    logic loopEn;
    int num_errors = 0;
    int compares = 0;

    always #50 clk = ~clk;

    lsdr_host_model i_lsdr_host_model (.clk(clk), .spiCsN(spiCsN), .spiSclk(spiSclk),
        .spiMosi(spiMosi), .spiMiso(spiMiso));
    lsdr_regs i_lsdr_regs (.clk(clk), .rst(rst), .spiCsN(spiCsN), .spiSclk(spiSclk),
        .spiMosi(spiMosi), .spiMiso(spiMiso), .spiMisoOe(), .loopClosureDet(det[0]),
        .ringTripDet(det[1]), .groundKeyDet(det[2]), .openVoltageTrackDet(det[3]),
        .speedupActive(det[4]), .commonModeOverDet(det[5]), .ringBurstActive(ringBurst),
        .autoStateValid(autoValid), .autoState(autoState), .commandedLineState(cmdState),
        .actualLineState(), .codecLoopbackEn(loopEn));

    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string name, input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [6:0] addr, input logic [7:0] data);
        logic [7:0] unused;
        i_lsdr_host_model.xfer({1'b0, addr, data}, unused);
    endtask : wr

    task automatic rdchk(input string name, input logic [6:0] addr, input logic [7:0] exp);
        logic [7:0] got;
        i_lsdr_host_model.xfer({1'b1, addr, 8'h00}, got);
        chk(name, got, exp);
    endtask : rdchk

    task automatic end_sim();
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : end_sim

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_loopback();
        rdchk("loopback reset", 7'h16, lsdr_pkg::LOOPBACK_RESET);
        rdchk("line feed reset", 7'h06, 8'h00);
        wr(7'h16, 8'h7F);
        rdchk("loopback reserved", 7'h16, 8'h00);
        wr(7'h16, 8'hFF);
        rdchk("loopback set", 7'h16, 8'h80);
        chk("loopback pin", {7'h00, loopEn}, 8'h01);
        wr(7'h16, 8'h00);
        chk("loopback pin off", {7'h00, loopEn}, 8'h00);
    endtask : t_loopback

    task automatic t_detect();
        for (int i = 0; i < 6; i++) begin
            det = 6'h01 << i;
            rdchk("detect flag", 7'h09, 8'h01 << i);
        end
        det = 6'h3F;
        wr(7'h09, 8'h00);
        rdchk("detect all", 7'h09, 8'h3F);
        det = 6'h00;
        rdchk("detect released", 7'h09, 8'h00);
    endtask : t_detect

    task automatic t_line_feed();
        logic [2:0] code;
        ringBurst = 1'b1;
        for (int i = 0; i < 8; i++) begin
            code = 3'(i);
            wr(7'h06, {5'h1F, code});
            chk("commanded pin", {5'h00, cmdState}, {5'h00, code});
            rdchk("line feed code", 7'h06, {1'b0, code, 1'b0, code});
        end
        ringBurst = 1'b0;
        wr(7'h06, 8'h04);
        rdchk("ring silent", 7'h06, 8'h24);
        autoState = 3'h5;
        autoValid = 1'b1;
        rdchk("auto override", 7'h06, 8'h54);
        autoValid = 1'b0;
        ringBurst = 1'b1;
        rdchk("ring burst", 7'h06, 8'h44);
        ringBurst = 1'b0;
        wr(7'h10, 8'hFF);
        rdchk("unmapped", 7'h10, 8'h00);
        rdchk("after unmapped", 7'h06, 8'h24);
    endtask : t_line_feed

    // A reset in mid-run must drop every written setting back to its reset value.
    task automatic t_reset();
        wr(7'h16, 8'h80);
        wr(7'h06, 8'h05);
        chk("loopback before reset", {7'h00, loopEn}, 8'h01);
        rst = 1'b1;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        chk("loopback pin reset", {7'h00, loopEn}, 8'h00);
        rdchk("loopback after reset", 7'h16, lsdr_pkg::LOOPBACK_RESET);
        rdchk("line feed after reset", 7'h06, 8'h00);
    endtask : t_reset

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (6) @(negedge clk);
        rst = 1'b0;
        repeat (2) @(negedge clk);
        t_loopback();
        t_detect();
        t_line_feed();
        t_reset();
        end_sim();
    end

    // About forty frames of some 140 cycles each fit well inside this span.
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_sim();
    end
endmodule : test_line_state_and_detect_regs
`default_nettype wire
